// ===== nvm_port_consts.svh
// constants for the parallel programming port of the non-volatile memory
`ifndef NVM_PORT_CONSTS_SVH
`define NVM_PORT_CONSTS_SVH
// Notes on behaviour
// [R01] programmer holds reset low, pulses load strobe six times, selects zero, waits 100ns; bench toggles it six times, three pulses
// [R02] entry refused if select pins change within 100ns after high voltage
// [R03] alternate entry: selects zero, power and high voltage together, then fix fuses
// [R04] command and address stay loaded across many operations
// [R05] address high byte holds until reloaded
// [R06] chip erase clears flash, eeprom, lock bits; fuses kept; locks released last
// [R07] eeprom preserve fuse programmed keeps eeprom through chip erase
// [R08] command 1000 0000 then program pulse starts chip erase, done low
// [R09] programmer waits for done high after chip erase before next command
// [R10] command 0001 0000 selects flash page write
// [R11] action 00 loads address byte, byte select one picks low or high
// [R12] action 01 loads data byte, byte select one picks low or high
// [R13] page latch with byte select one high stores data word in buffer
// [R14] low address bits pick word in page, upper bits pick page
// [R15] program pulse with byte select one low writes whole flash page
// [R16] command 0000 0000 is no operation and ends page programming
// [R17] command 0001 0001 writes eeprom page through latched buffer
// [R18] command 0000 0010 reads flash word low or high byte while drive low
// [R19] command 0000 0011 reads eeprom byte while drive low
// [R20] command 0100 0000 with both selects low writes low fuse byte
// [R21] same command with byte select one high writes high fuse byte
// [R22] command 0010 0000 programs lock bits with zero data; only erase clears
// [R23] done flag is 0 while busy and 1 when ready
// [R24] data bus is driven only while read drive is low
// [R25] inputs sampled at load strobe rise; action 11 ignored
`define CMD_CHIP_ERASE 8'h80
`define CMD_WRITE_FUSE 8'h40
`define CMD_WRITE_LOCK 8'h20
`define CMD_WRITE_FLASH 8'h10
`define CMD_WRITE_EEPROM 8'h11
`define CMD_READ_FLASH 8'h02
`define CMD_READ_EEPROM 8'h03
`define CMD_NOP 8'h00
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define FLASH_WORDS 4096
`define FLASH_AW 12
`define FLASH_PAGE_WORDS 32
`define FLASH_WORD_BITS 5
`define EE_BYTES 512
`define EE_AW 9
`define EE_PAGE_BYTES 4
`define EE_WORD_BITS 2
`define FUSE_LOW_RESET 8'he1
`define FUSE_HIGH_RESET 8'hd9
`define LOCK_RESET 8'hff
`define EE_PRESERVE_BIT 3
`define CLK_MHZ 20
// entry settle window after reset rise: 100ns at the 50ns clock
`define ENTRY_SETTLE_CYCLES 2
`define WRITE_TIME_US 4
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_MHZ)
`define ERASE_TIME_US 8000
`define ERASE_CYCLES (`ERASE_TIME_US * `CLK_MHZ)
`endif

// ===== nvm_port_pkg.sv
// types for the parallel programming port
package nvm_port_pkg;
  typedef enum logic [2:0] {
    IDLE, PROG_FLASH, PROG_EEPROM, ERASE_FLASH, ERASE_EEPROM, ERASE_LOCK
  } seq_state_t;
endpackage : nvm_port_pkg

// ===== nvm_prog_port.sv
// device side of the high-voltage parallel programming port
`timescale 1ns/10ps
`include "nvm_port_consts.svh"
module nvm_prog_port #(
  parameter int ERASE_CYCLES = `ERASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // programmer strobes and selects
  input wire logic load_strobe,
  input wire logic page_latch_strobe,
  input wire logic write_pulse_n,
  input wire logic read_drive_n,
  input wire logic action_select_high,
  input wire logic action_select_low,
  input wire logic byte_select_one,
  input wire logic byte_select_two,
  // data bus, three signals
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // status
  output logic done_flag,
  output logic [7:0] fuse_low,
  output logic [7:0] fuse_high,
  output logic [7:0] lock_bits
);
  // ==========================================================
  // programming-mode entry
  // reset high stands for the programming voltage; the entry-select pins
  // must stay at zero through the settle window, or every strobe but read drive is
  // ignored until the next reset (a refused entry is silent by design)
  logic [3:0] entry_pins;
  logic [1:0] entry_cnt;
  logic entry_bad;
  logic prog_mode;
  assign entry_pins = {page_latch_strobe, action_select_high, action_select_low,
                       byte_select_one};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_cnt <= 2'h0;
      entry_bad <= 1'b0;
    end else if (entry_cnt != 2'(`ENTRY_SETTLE_CYCLES)) begin
      entry_cnt <= entry_cnt + 2'h1;
      if (entry_pins != 4'h0) begin
        entry_bad <= 1'b1; // R02
      end
    end
  end

  // the same check serves both entry orders, since the block only sees reset rise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_mode <= 1'b0;
    end else if (entry_cnt == 2'(`ENTRY_SETTLE_CYCLES - 1)) begin
      prog_mode <= !entry_bad && entry_pins == 4'h0; // R02 R03
    end
  end

  // ==========================================================
  // strobe edges
  logic load_q, latch_q, wr_q;
  logic load_rise, latch_rise, wr_fall;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_q <= 1'b0;
      latch_q <= 1'b0;
      wr_q <= 1'b1;
    end else begin
      load_q <= load_strobe;
      latch_q <= page_latch_strobe;
      wr_q <= write_pulse_n;
    end
  end
  assign load_rise = prog_mode && load_strobe && !load_q; // R25
  assign latch_rise = prog_mode && page_latch_strobe && !latch_q;
  assign wr_fall = prog_mode && !write_pulse_n && wr_q;

  // ==========================================================
  // command, address and data latches
  logic [7:0] command, addr_low, addr_high, data_low, data_high;
  logic [1:0] action;
  nvm_port_pkg::seq_state_t state;
  logic busy;
  logic [17:0] cnt;
  assign action = {action_select_high, action_select_low};
  assign busy = (state != nvm_port_pkg::IDLE);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      command <= `CMD_NOP;
      addr_low <= 8'h00;
      addr_high <= 8'h00;
      data_low <= 8'h00;
      data_high <= 8'h00;
    end else if (load_rise && !busy) begin // R25
      case (action)
        `ACT_CMD: command <= data_in; // R04
        `ACT_ADDR: begin // R11
          if (byte_select_one) begin
            addr_high <= data_in; // R05
          end else begin
            addr_low <= data_in;
          end
        end
        `ACT_DATA: begin // R12
          if (byte_select_one) begin
            data_high <= data_in;
          end else begin
            data_low <= data_in;
          end
        end
        default: ; // action 11 is idle R25
      endcase
    end
  end

  // ==========================================================
  // memories and page buffers
  logic [15:0] flash_mem [`FLASH_WORDS];
  logic [7:0] ee_mem [`EE_BYTES];
  logic [15:0] flash_buf [`FLASH_PAGE_WORDS];
  logic [7:0] ee_buf [`EE_PAGE_BYTES];
  logic [`FLASH_PAGE_WORDS-1:0] flash_buf_valid;
  logic [`EE_PAGE_BYTES-1:0] ee_buf_valid;
  logic [`FLASH_AW-1:0] flash_addr;
  logic [`EE_AW-1:0] ee_addr;
  assign flash_addr = {addr_high[3:0], addr_low}; // R14
  assign ee_addr = {addr_high[0], addr_low};

  // page base: word bits cleared, top low-byte bits join the page number
  function automatic logic [`FLASH_AW-1:0] flash_page_base(input logic [`FLASH_AW-1:0] a);
    flash_page_base = {a[`FLASH_AW-1:`FLASH_WORD_BITS], {`FLASH_WORD_BITS{1'b0}}}; // R14
  endfunction : flash_page_base

  function automatic logic [`EE_AW-1:0] ee_page_base(input logic [`EE_AW-1:0] a);
    ee_page_base = {a[`EE_AW-1:`EE_WORD_BITS], {`EE_WORD_BITS{1'b0}}};
  endfunction : ee_page_base

  logic nop_load;
  assign nop_load = load_rise && !busy && action == `ACT_CMD && data_in == `CMD_NOP;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_buf_valid <= '0;
      ee_buf_valid <= '0;
    end else if (nop_load) begin
      flash_buf_valid <= '0; // R16
      ee_buf_valid <= '0;
    end else if (state == nvm_port_pkg::PROG_FLASH && cnt == '0) begin
      flash_buf_valid <= '0;
    end else if (state == nvm_port_pkg::PROG_EEPROM && cnt == '0) begin
      ee_buf_valid <= '0;
    end else if (latch_rise && !busy && byte_select_one) begin // R13
      if (command == `CMD_WRITE_FLASH) begin
        flash_buf_valid[flash_addr[`FLASH_WORD_BITS-1:0]] <= 1'b1;
      end else if (command == `CMD_WRITE_EEPROM) begin // R17
        ee_buf_valid[ee_addr[`EE_WORD_BITS-1:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (latch_rise && !busy && byte_select_one) begin
      flash_buf[flash_addr[`FLASH_WORD_BITS-1:0]] <= {data_high, data_low}; // R13
      ee_buf[ee_addr[`EE_WORD_BITS-1:0]] <= data_low;
    end
  end

  // ==========================================================
  // sequencer: timed write and erase
  logic [`FLASH_AW-1:0] sweep;
  logic ee_keep;
  assign ee_keep = !fuse_high[`EE_PRESERVE_BIT]; // R07

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= nvm_port_pkg::IDLE;
      cnt <= '0;
      sweep <= '0;
    end else begin
      case (state)
        nvm_port_pkg::IDLE: begin
          sweep <= '0;
          if (wr_fall) begin
            cnt <= 18'(`WRITE_CYCLES - 1);
            case (command)
              `CMD_CHIP_ERASE: begin // R08
                state <= nvm_port_pkg::ERASE_FLASH;
                cnt <= 18'(ERASE_CYCLES - 1);
              end
              `CMD_WRITE_FLASH: if (!byte_select_one) state <= nvm_port_pkg::PROG_FLASH; // R10 R15
              `CMD_WRITE_EEPROM: if (!byte_select_one) state <= nvm_port_pkg::PROG_EEPROM; // R17
              default: ;
            endcase
          end
        end
        nvm_port_pkg::PROG_FLASH, nvm_port_pkg::PROG_EEPROM: begin
          if (cnt == '0) begin
            state <= nvm_port_pkg::IDLE;
          end else begin
            cnt <= cnt - 18'd1;
          end
        end
        nvm_port_pkg::ERASE_FLASH: begin
          // one word per cycle; the remaining time pads to the erase duration
          sweep <= sweep + `FLASH_AW'(1);
          if (cnt != '0) begin
            cnt <= cnt - 18'd1;
          end
          if (sweep == '1) begin
            state <= nvm_port_pkg::ERASE_EEPROM; // R06
          end
        end
        nvm_port_pkg::ERASE_EEPROM: begin
          sweep <= sweep + `FLASH_AW'(1);
          if (cnt != '0) begin
            cnt <= cnt - 18'd1;
          end
          if (ee_keep || sweep[`EE_AW-1:0] == '1) begin // R07
            state <= nvm_port_pkg::ERASE_LOCK;
          end
        end
        nvm_port_pkg::ERASE_LOCK: begin
          if (cnt == '0) begin
            state <= nvm_port_pkg::IDLE;
          end else begin
            cnt <= cnt - 18'd1;
          end
        end
        default: state <= nvm_port_pkg::IDLE;
      endcase
    end
  end

  // ==========================================================
  // array updates
  always_ff @(posedge core_clk) begin
    case (state)
      nvm_port_pkg::PROG_FLASH: begin
        if (cnt == '0) begin
          for (int i = 0; i < `FLASH_PAGE_WORDS; i++) begin
            if (flash_buf_valid[i]) begin
              flash_mem[flash_page_base(flash_addr) | `FLASH_AW'(i)] <= flash_buf[i]; // R15
            end
          end
        end
      end
      nvm_port_pkg::PROG_EEPROM: begin
        if (cnt == '0) begin
          for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
            if (ee_buf_valid[i]) begin
              ee_mem[ee_page_base(ee_addr) | `EE_AW'(i)] <= ee_buf[i]; // R17
            end
          end
        end
      end
      nvm_port_pkg::ERASE_FLASH: flash_mem[sweep] <= 16'hffff; // R06
      nvm_port_pkg::ERASE_EEPROM: if (!ee_keep) ee_mem[sweep[`EE_AW-1:0]] <= 8'hff;
      default: ;
    endcase
  end

  // ==========================================================
  // fuses and lock bits; fuses untouched by erase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_low <= `FUSE_LOW_RESET;
      fuse_high <= `FUSE_HIGH_RESET;
      lock_bits <= `LOCK_RESET;
    end else if (state == nvm_port_pkg::ERASE_LOCK && cnt == '0) begin
      lock_bits <= `LOCK_RESET; // R06
    end else if (wr_fall && !busy) begin
      if (command == `CMD_WRITE_FUSE && !byte_select_two) begin
        if (byte_select_one) begin
          fuse_high <= data_low; // R21
        end else begin
          fuse_low <= data_low; // R20
        end
      end else if (command == `CMD_WRITE_LOCK) begin
        lock_bits <= lock_bits & data_low; // R22
      end
    end
  end

  // a pulse under these commands touches only fuse or lock bytes
  function automatic logic short_write(input logic [7:0] cmd, input logic bs2);
    short_write = (cmd == `CMD_WRITE_FUSE && !bs2) || cmd == `CMD_WRITE_LOCK;
  endfunction : short_write

  // only a pulse that really starts timed work may pull done low
  function automatic logic starts_op(input logic [7:0] cmd, input logic bs1, input logic bs2);
    case (cmd)
      `CMD_CHIP_ERASE: starts_op = 1'b1;
      `CMD_WRITE_FLASH, `CMD_WRITE_EEPROM: starts_op = !bs1;
      default: starts_op = short_write(cmd, bs2);
    endcase
  endfunction : starts_op

  // fuse and lock writes are short; a counter keeps done low for the write time
  logic [6:0] short_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      short_cnt <= '0;
    end else if (wr_fall && !busy && short_write(command, byte_select_two)) begin
      short_cnt <= 7'(`WRITE_CYCLES);
    end else if (short_cnt != '0) begin
      short_cnt <= short_cnt - 7'd1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_flag <= 1'b1;
    end else begin
      done_flag <= !(busy || short_cnt != '0 ||
                     (wr_fall && starts_op(command, byte_select_one, byte_select_two))); // R23
    end
  end

  // ==========================================================
  // read path
  logic [15:0] flash_rd;
  logic [7:0] ee_rd;
  always_ff @(posedge core_clk) begin
    flash_rd <= flash_mem[flash_addr];
    ee_rd <= ee_mem[ee_addr];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_oe <= !read_drive_n; // R24
      if (command == `CMD_READ_FLASH) begin
        data_out <= byte_select_one ? flash_rd[15:8] : flash_rd[7:0]; // R18
      end else if (command == `CMD_READ_EEPROM && !byte_select_one) begin
        data_out <= ee_rd; // R19
      end else begin
        data_out <= 8'h00;
      end
    end
  end
endmodule : nvm_prog_port

// ===== nvm_prog_port_properties.sv
// checker for the parallel programming port
`timescale 1ns/10ps
module nvm_prog_port_properties #(
  parameter int ERASE_CYCLES = 5000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // watched signals
  input wire logic write_pulse_n,
  input wire logic read_drive_n,
  input wire logic data_oe,
  input wire logic done_flag,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [7:0] lock_bits
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ====
  // busy length, held after completion so a late lock release can be judged
  logic done_q;
  int busy_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b1;
      busy_cnt <= 0;
    end else begin
      done_q <= done_flag;
      if (done_q && !done_flag) busy_cnt <= 1;
      else if (!done_flag) busy_cnt <= busy_cnt + 1;
    end
  end
  // ====
  // assertions
  a_drive_on_read: assert property (!read_drive_n ##1 !read_drive_n |-> data_oe)
    else $error("bus not driven during read");
  a_release_bus: assert property (read_drive_n |=> !data_oe)
    else $error("bus driven outside read");
  a_busy_has_cause: assert property ($fell(done_flag) |->
    !$past(write_pulse_n) || !$past(write_pulse_n, 2) || !$past(write_pulse_n, 3))
    else $error("busy without write pulse");
  a_busy_min_len: assert property ($fell(done_flag) |-> !done_flag [*8])
    else $error("busy too short");
  a_busy_bounded: assert property (busy_cnt <= ERASE_CYCLES + 8000)
    else $error("busy never ends");
  a_fuse_lock_idle: assert property (done_flag [*3] |->
    $stable(fuse_low) && $stable(fuse_high) && $stable(lock_bits))
    else $error("fuse or lock changed while idle");
  a_fuse_one_byte: assert property ($changed(fuse_low) |-> $stable(fuse_high))
    else $error("both fuse bytes changed");
  a_lock_release_late: assert property (|(lock_bits & ~$past(lock_bits)) |->
    busy_cnt > 4096)
    else $error("lock released too early");
  c_busy: cover property ($fell(done_flag));
  c_read: cover property (data_oe);
  c_fuse: cover property ($changed(fuse_high));
endmodule : nvm_prog_port_properties

bind nvm_prog_port nvm_prog_port_properties #(.ERASE_CYCLES(ERASE_CYCLES)) checker_i (
  .core_clk(core_clk), .rst_n(rst_n), .write_pulse_n(write_pulse_n),
  .read_drive_n(read_drive_n), .data_oe(data_oe), .done_flag(done_flag),
  .fuse_low(fuse_low), .fuse_high(fuse_high), .lock_bits(lock_bits));

// ===== nvm_programmer.sv
// behavioural programmer driving the parallel port
`timescale 1ns/10ps
module nvm_programmer (
  // from the device
  input wire logic core_clk,
  input wire logic done_flag,
  input wire logic data_oe,
  input wire logic [7:0] data_out,
  // strobes and selects
  output logic load_strobe,
  output logic page_latch_strobe,
  output logic write_pulse_n,
  output logic read_drive_n,
  output logic action_select_high,
  output logic action_select_low,
  output logic byte_select_one,
  output logic byte_select_two,
  // resolved data bus
  output logic [7:0] data_in
);
  // released bus shows the inverse of the last value, so stale data never matches
  logic [7:0] drv = 8'h00;
  assign data_in = data_oe ? data_out : drv;
  initial begin
    {load_strobe, page_latch_strobe, byte_select_one, byte_select_two} = 4'h0;
    {action_select_high, action_select_low, write_pulse_n, read_drive_n} = 4'h3;
  end
  // entry: load strobe toggled under reset, entry-select pins then held
  task automatic enter_mode(input logic bad);
    {page_latch_strobe, action_select_high, action_select_low} = 3'h0;
    byte_select_one = 1'b0;
    repeat (6) begin
      #2 load_strobe = ~load_strobe;
    end
    byte_select_one = bad;
  endtask : enter_mode
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask : tick
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
    {action_select_high, action_select_low} = act;
    byte_select_one = bs1;
    drv = d;
    tick(1);
    load_strobe = 1'b1;
    tick(2);
    load_strobe = 1'b0;
    tick(1);
    drv = ~d;
  endtask : load
  task automatic latch();
    byte_select_one = 1'b1;
    tick(1);
    page_latch_strobe = 1'b1;
    tick(2);
    page_latch_strobe = 1'b0;
    tick(1);
  endtask : latch
  task automatic pulse_write(input logic bs1, input logic bs2, output logic busy);
    byte_select_one = bs1;
    byte_select_two = bs2;
    tick(1);
    write_pulse_n = 1'b0;
    tick(2);
    busy = !done_flag;
    write_pulse_n = 1'b1;
    for (int n = 0; n < 20000 && done_flag !== 1'b1; n++) tick(1);
    byte_select_one = 1'b0;
    tick(1);
  endtask : pulse_write
  task automatic fetch(input logic bs1, output logic [7:0] d, output logic oe);
    byte_select_one = bs1;
    read_drive_n = 1'b0;
    tick(4);
    d = data_in;
    oe = data_oe;
    read_drive_n = 1'b1;
    tick(2);
  endtask : fetch
endmodule : nvm_programmer

// ===== parallel_nvm_programming_port_test.sv
// self-checking bench for the parallel programming port
`timescale 1ns/10ps
`include "nvm_port_consts.svh"
module parallel_nvm_programming_port_test;
  logic core_clk, rst_n, load_strobe, page_latch_strobe, write_pulse_n, read_drive_n;
  logic action_select_high, action_select_low, byte_select_one, byte_select_two;
  logic data_oe, done_flag, busy;
  logic [7:0] data_in, data_out, fuse_low, fuse_high, lock_bits, ah, fb, eh, eb, v;
  int mismatches = 0;
  int samples_checked = 0;
  logic [15:0] lfsr = 16'h755c;
  int fm[int];
  int em[int];
  logic [7:0] fl = `FUSE_LOW_RESET;
  logic [7:0] fh = `FUSE_HIGH_RESET;
  logic [7:0] lk = `LOCK_RESET;
  nvm_prog_port #(.ERASE_CYCLES(5000)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .load_strobe(load_strobe), .page_latch_strobe(page_latch_strobe),
    .write_pulse_n(write_pulse_n), .read_drive_n(read_drive_n),
    .action_select_high(action_select_high), .action_select_low(action_select_low),
    .byte_select_one(byte_select_one), .byte_select_two(byte_select_two),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .done_flag(done_flag),
    .fuse_low(fuse_low), .fuse_high(fuse_high), .lock_bits(lock_bits));
  nvm_programmer programmer (.core_clk(core_clk), .done_flag(done_flag),
    .data_oe(data_oe), .data_out(data_out), .load_strobe(load_strobe),
    .page_latch_strobe(page_latch_strobe), .write_pulse_n(write_pulse_n),
    .read_drive_n(read_drive_n), .action_select_high(action_select_high),
    .action_select_low(action_select_low), .byte_select_one(byte_select_one),
    .byte_select_two(byte_select_two), .data_in(data_in));
  // ====
  // helpers
  function automatic logic [7:0] next_rand();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : next_rand
  function automatic int addr_key(input logic flash, input logic [7:0] h, input logic [7:0] l);
    return flash ? int'({h[3:0], l}) : int'({h[0], l});
  endfunction : addr_key
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic erase();
    programmer.load(`ACT_CMD, 1'b0, `CMD_CHIP_ERASE);
    programmer.pulse_write(1'b0, 1'b0, busy);
    chk({7'h0, busy}, 8'h01);
    fm.delete();
    if (fh[`EE_PRESERVE_BIT]) em.delete();
    lk = `LOCK_RESET;
    chk(lock_bits, lk);
    chk(fuse_high, fh);
  endtask : erase
  // writes words 0, 1 and the last of a page
  task automatic write_page(input logic flash, input logic [7:0] h, input logic [7:0] b);
    logic [7:0] lo, hi;
    programmer.load(`ACT_CMD, 1'b0, flash ? `CMD_WRITE_FLASH : `CMD_WRITE_EEPROM);
    programmer.load(`ACT_ADDR, 1'b1, h);
    for (int o = 0; o < 32; o++) begin
      if (o < 2 || o == (flash ? 31 : 3)) begin
        lo = next_rand();
        hi = next_rand();
        programmer.load(`ACT_ADDR, 1'b0, b | 8'(o));
        programmer.load(`ACT_DATA, 1'b0, lo);
        programmer.load(`ACT_DATA, 1'b1, hi);
        programmer.latch();
        if (flash) fm[addr_key(1'b1, h, b | 8'(o))] = {hi, lo};
        else em[addr_key(1'b0, h, b | 8'(o))] = lo;
      end
    end
    programmer.pulse_write(1'b0, 1'b0, busy);
    chk({7'h0, busy}, 8'h01);
  endtask : write_page
  task automatic verify(input logic flash, input logic [7:0] h, input logic [7:0] b);
    logic [7:0] d;
    logic oe;
    int k, x;
    programmer.load(`ACT_CMD, 1'b0, flash ? `CMD_READ_FLASH : `CMD_READ_EEPROM);
    programmer.load(`ACT_ADDR, 1'b1, h);
    for (int o = 0; o < 32; o++) begin
      if (o < 3 || o == (flash ? 31 : 3)) begin
        k = addr_key(flash, h, b | 8'(o));
        x = flash ? (fm.exists(k) ? fm[k] : 16'hffff) : (em.exists(k) ? em[k] : 8'hff);
        programmer.load(`ACT_ADDR, 1'b0, b | 8'(o));
        programmer.load(2'h3, 1'b0, ~b);
        programmer.fetch(1'b0, d, oe);
        chk({7'h0, oe}, 8'h01);
        chk(d, 8'(x));
        if (flash) begin
          programmer.fetch(1'b1, d, oe);
          chk(d, 8'(x >> 8));
        end
      end
    end
  endtask : verify
  // ====
  // clock, watchdog and test sequence
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    programmer.enter_mode(1'b0);
    repeat (2) @(posedge core_clk);
    #5 rst_n = 1'b1;
    programmer.tick(2);
    chk({6'h0, done_flag, data_oe}, 8'h02);
    chk(fuse_low, fl);
    erase();
    $display("test reset and erase done");
    ah = next_rand();
    fb = next_rand() & 8'he0;
    eh = next_rand();
    eb = next_rand() & 8'hfc;
    write_page(1'b1, ah, fb);
    programmer.load(`ACT_CMD, 1'b0, `CMD_NOP);
    programmer.pulse_write(1'b0, 1'b0, busy);
    chk({7'h0, busy}, 8'h00);
    write_page(1'b0, eh, eb);
    verify(1'b1, ah, fb);
    verify(1'b0, eh, eb);
    $display("test page write and read done");
    v = next_rand();
    programmer.load(`ACT_CMD, 1'b0, `CMD_WRITE_FUSE);
    programmer.load(`ACT_DATA, 1'b0, v);
    programmer.pulse_write(1'b0, 1'b0, busy);
    fl = v;
    chk(fuse_low, fl);
    fh = next_rand() & 8'hf7;
    programmer.load(`ACT_DATA, 1'b0, fh);
    programmer.pulse_write(1'b1, 1'b0, busy);
    chk(fuse_high, fh);
    chk(fuse_low, fl);
    v = next_rand() & 8'hf0;
    programmer.load(`ACT_CMD, 1'b0, `CMD_WRITE_LOCK);
    programmer.load(`ACT_DATA, 1'b0, v);
    programmer.pulse_write(1'b0, 1'b0, busy);
    lk = lk & v;
    chk(lock_bits, lk);
    programmer.load(`ACT_DATA, 1'b0, 8'hff);
    programmer.pulse_write(1'b0, 1'b0, busy);
    chk(lock_bits, lk);
    $display("test fuse and lock done");
    erase();
    verify(1'b1, ah, fb);
    verify(1'b0, eh, eb);
    $display("test erase with preserved eeprom done");
    rst_n = 1'b0;
    programmer.enter_mode(1'b1);
    repeat (2) @(posedge core_clk);
    #5 rst_n = 1'b1;
    programmer.tick(2);
    programmer.load(`ACT_CMD, 1'b0, `CMD_WRITE_FUSE);
    programmer.load(`ACT_DATA, 1'b0, 8'h00);
    programmer.pulse_write(1'b0, 1'b0, busy);
    chk({7'h0, busy}, 8'h00);
    chk(fuse_low, `FUSE_LOW_RESET);
    $display("test refused entry done");
    print_verdict();
  end
endmodule : parallel_nvm_programming_port_test
